// file: rtl/cache_cfg_map.vh
// Purpose: field positions, offsets and reset values for the board cache
//          configuration and tag capture registers
// Assumes: included by bare name from the rtl modules
// Notes:   definitions only
`ifndef CACHE_CFG_MAP_VH
`define CACHE_CFG_MAP_VH

`define TAG_CAPTURE_OFFSET 40'hFFFFF00108
`define TIMING_CONFIG_OFFSET 40'hFFFFF001C8
`define ERROR_STATUS_OFFSET 40'hFFFFF00168

`define SIZE_LSB 0
`define SIZE_MSB 2
`define RD_LSB 4
`define RD_MSB 7
`define WR_LSB 8
`define WR_MSB 11
`define GAP_LSB 12
`define GAP_MSB 14
`define OFS_LSB 16
`define OFS_MSB 18
`define WE_LSB 20
`define WE_MSB 28

`define SIZE_RESET 3'h1
`define RD_RESET 4'h4
`define WR_RESET 4'h4
`define GAP_RESET 3'h7
`define OFS_RESET 3'h1
`define WE_RESET 9'h000

`define SIZE_NONE 3'h0
`define GAP_FIXED 4'h3

`define CAP_HIT 12
`define CAP_TSP 13
`define CAP_DIRTY 14
`define CAP_SHARED 15
`define CAP_VALID 16
`define CAP_TP 17
`define CAP_TAG_LSB 20
`define CAP_TAG_MSB 38

`endif

// file: rtl/write_pulse_shifter.v
// Purpose: shifts the write-pulse pattern out one bit per cpu cycle
// Assumes: start pulses only while idle; pattern held stable by caller
// Notes:   fills wait the programmed offset first, private writes do not
`include "cache_cfg_map.vh"
module write_pulse_shifter #(
    parameter PAT_W = 9
) (
    input wire core_clk,
    input wire rst_n,
    input wire start_private,
    input wire start_fill,
    input wire [PAT_W-1:0] pattern,
    input wire [2:0] fill_offset,
    output reg write_pulse,
    output reg busy
);
    reg [2:0] wait_cnt;
    reg [PAT_W-1:0] shift;
    reg [3:0] bits_left;
    localparam [3:0] BITS_ALL = PAT_W;
    localparam [3:0] BITS_REST = PAT_W - 1;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            wait_cnt <= 3'h0;
            shift <= {PAT_W{1'b0}};
            bits_left <= 4'h0;
            write_pulse <= 1'b0;
            busy <= 1'b0;
        end else if (start_private && !busy) begin
            // no offset: bit zero lands in the index-drive cycle
            write_pulse <= pattern[0];
            shift <= pattern >> 1;
            bits_left <= BITS_REST;
            wait_cnt <= 3'h0;
            busy <= 1'b1;
        end else if (start_fill && !busy) begin
            // start is the sysclk output edge; count offset cycles first
            write_pulse <= 1'b0;
            shift <= pattern;
            bits_left <= BITS_ALL;
            wait_cnt <= fill_offset;
            busy <= 1'b1;
        end else if (busy) begin
            if (wait_cnt != 3'h0) begin
                wait_cnt <= wait_cnt - 3'h1;
                write_pulse <= 1'b0;
            end else if (bits_left != 4'h0) begin
                write_pulse <= shift[0];
                shift <= shift >> 1;
                bits_left <= bits_left - 4'h1;
            end else begin
                write_pulse <= 1'b0;
                busy <= 1'b0;
            end
        end else begin
            write_pulse <= 1'b0;
        end
    end
endmodule

// file: rtl/read_write_gap.v
// Purpose: spacing counter from a private read to a private write
// Assumes: read_done pulses at the end of each private read
// Notes:   only private traffic is spaced; system moves are not
`include "cache_cfg_map.vh"
module read_write_gap (
    input wire core_clk,
    input wire rst_n,
    input wire read_done,
    input wire [2:0] gap,
    output reg write_hold
);
    reg [3:0] remain;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            remain <= 4'h0;
            write_hold <= 1'b0;
        end else if (read_done) begin
            // fixed three cycles always added to the programmed gap
            remain <= {1'b0, gap} + `GAP_FIXED;
            write_hold <= 1'b1;
        end else if (remain > 4'h1) begin
            remain <= remain - 4'h1;
        end else begin
            remain <= 4'h0;
            write_hold <= 1'b0;
        end
    end
endmodule

// file: rtl/board_cache_timing_tag_capture.v
// Purpose: board cache configuration register and tag capture register
// Assumes: register port accesses are one-cycle strobes with a 40-bit address
// Notes:   config is write only; capture survives reset in lock state and data
`include "cache_cfg_map.vh"
// Operation
// - power-up loads defaults, timeout reset keeps them
// - size code 0 none, else 1MB doubling
// - read access cycles in 7:4, 4 to 10
// - write cycles in 11:8, 4 to 10
// - read-to-write gap 14:12, minimum one, reset seven
// - always add three cycles to gap
// - fill offset 18:16 waits after sysclk edge
// - offset ignored for private writes
// - pattern bit per cycle, bit zero first
// - private and shared writes use pattern directly
// - fills wait offset then shift pattern
// - unlocked capture loads every tag read
// - tag or control parity error locks capture
// - status read or force hit unlocks; reset keeps
// - unused tag bits read zero by size
// - capture layout hit, parities, state, tag
// - system-command parity error capture address unreliable
// - force hit makes cached references hit
module board_cache_timing_tag_capture #(
    parameter TAG_W = 19
) (
    input wire core_clk,
    input wire rst_n,
    input wire timeout_reset,
    input wire reg_wr,
    input wire reg_rd,
    input wire [39:0] reg_addr,
    input wire [63:0] reg_wdata,
    input wire force_hit_mode,
    input wire tag_read,
    input wire tag_hit,
    input wire [TAG_W-1:0] tag_bits,
    input wire tag_parity,
    input wire tag_status_parity,
    input wire tag_dirty_bit,
    input wire tag_shared_bit,
    input wire tag_valid_bit,
    input wire tag_parity_err,
    input wire tag_ctl_parity_err,
    input wire system_cmd,
    input wire cached_ref,
    input wire private_write_start,
    input wire fill_write_start,
    input wire private_read_done,
    output reg [63:0] reg_rdata,
    output reg rdata_valid,
    output reg [2:0] cache_size_field,
    output reg [3:0] read_access_cycles,
    output reg [3:0] write_cycles,
    output reg cache_present,
    output reg force_hit,
    output reg write_pulse,
    output reg write_busy,
    output reg write_hold,
    output reg capture_locked,
    output reg capture_suspect
);
    reg [2:0] read_to_write_gap;
    reg [2:0] fill_offset;
    reg [8:0] write_pulse_pattern;
    reg [63:0] cache_tag_capture;
    reg [TAG_W-1:0] tag_mask;
    reg force_hit_q;
    reg [63:0] next_capture;
    wire cfg_sel;
    wire cap_sel;
    wire stat_sel;
    wire pulse_w;
    wire busy_w;
    wire hold_w;
    wire unlock;
    integer i;

    assign cfg_sel = (reg_addr == `TIMING_CONFIG_OFFSET);
    assign cap_sel = (reg_addr == `TAG_CAPTURE_OFFSET);
    assign stat_sel = (reg_addr == `ERROR_STATUS_OFFSET);
    // entering force hit is the rising edge of the mode bit
    assign unlock = (reg_rd && stat_sel) || (force_hit_mode && !force_hit_q);

    always @(posedge core_clk) begin
        if (!rst_n) begin
            cache_size_field <= `SIZE_RESET;
            read_access_cycles <= `RD_RESET;
            write_cycles <= `WR_RESET;
            read_to_write_gap <= `GAP_RESET;
            fill_offset <= `OFS_RESET;
            write_pulse_pattern <= `WE_RESET;
        end else if (reg_wr && cfg_sel && !timeout_reset) begin
            // reserved and upper bits are simply not stored
            cache_size_field <= reg_wdata[`SIZE_MSB:`SIZE_LSB];
            read_access_cycles <= reg_wdata[`RD_MSB:`RD_LSB];
            write_cycles <= reg_wdata[`WR_MSB:`WR_LSB];
            read_to_write_gap <= reg_wdata[`GAP_MSB:`GAP_LSB];
            fill_offset <= reg_wdata[`OFS_MSB:`OFS_LSB];
            write_pulse_pattern <= reg_wdata[`WE_MSB:`WE_LSB];
        end
    end

    // timeout reset only keeps config; sync reset path above is power-up
    // size 1 uses the full tag, each doubling drops one low tag bit
    always @* begin
        tag_mask = {TAG_W{1'b1}};
        for (i = 0; i < TAG_W; i = i + 1) begin
            if (cache_size_field == `SIZE_NONE) begin
                tag_mask[i] = 1'b0;
            end else if (i < cache_size_field - 3'h1) begin
                tag_mask[i] = 1'b0;
            end
        end
    end

    always @* begin
        next_capture = 64'h0000000000000000;
        next_capture[`CAP_HIT] = tag_hit || force_hit;
        next_capture[`CAP_TSP] = tag_status_parity;
        next_capture[`CAP_DIRTY] = tag_dirty_bit;
        next_capture[`CAP_SHARED] = tag_shared_bit;
        next_capture[`CAP_VALID] = tag_valid_bit;
        next_capture[`CAP_TP] = tag_parity;
        next_capture[`CAP_TAG_MSB:`CAP_TAG_LSB] = tag_bits & tag_mask;
    end

    // capture data and lock have no reset: they must survive it
    always @(posedge core_clk) begin
        force_hit_q <= rst_n ? force_hit_mode : 1'b0;
        if (tag_read && (!capture_locked || unlock)) begin
            cache_tag_capture <= next_capture;
            capture_suspect <= system_cmd && tag_parity_err;
        end
        if (tag_read && (tag_parity_err || tag_ctl_parity_err)) begin
            capture_locked <= 1'b1;
        end else if (unlock) begin
            capture_locked <= 1'b0;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 64'h0000000000000000;
            rdata_valid <= 1'b0;
            cache_present <= 1'b0;
            force_hit <= 1'b0;
            write_pulse <= 1'b0;
            write_busy <= 1'b0;
            write_hold <= 1'b0;
        end else begin
            // config is write only, so only the capture returns data
            rdata_valid <= reg_rd;
            reg_rdata <= (reg_rd && cap_sel) ? cache_tag_capture : 64'h0000000000000000;
            cache_present <= (cache_size_field != `SIZE_NONE);
            force_hit <= force_hit_mode && (cache_size_field != `SIZE_NONE) && cached_ref;
            write_pulse <= pulse_w;
            write_busy <= busy_w;
            write_hold <= hold_w;
        end
    end

    write_pulse_shifter #(
        .PAT_W(9)
    ) u_shifter (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start_private(private_write_start),
        .start_fill(fill_write_start),
        .pattern(write_pulse_pattern),
        .fill_offset(fill_offset),
        .write_pulse(pulse_w),
        .busy(busy_w)
    );

    read_write_gap u_gap (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .read_done(private_read_done),
        .gap(read_to_write_gap),
        .write_hold(hold_w)
    );
endmodule

// file: verif/cache_tag_checker_assertions.sv
// Purpose: port checks for the board cache timing and tag capture block
// Assumes: one clock, synchronous active-low reset
// Notes: the capture lock is not reset, so reset cycles are skipped only
module cache_tag_checker (
    input wire core_clk,
    input wire rst_n,
    input wire timeout_reset,
    input wire reg_rd,
    input wire [39:0] reg_addr,
    input wire [63:0] reg_rdata,
    input wire rdata_valid,
    input wire force_hit_mode,
    input wire cached_ref,
    input wire tag_read,
    input wire tag_parity_err,
    input wire tag_ctl_parity_err,
    input wire private_read_done,
    input wire [2:0] cache_size_field,
    input wire [3:0] read_access_cycles,
    input wire [3:0] write_cycles,
    input wire cache_present,
    input wire force_hit,
    input wire write_hold,
    input wire capture_locked
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire [10:0] cfg = {cache_size_field, read_access_cycles, write_cycles};
    wire st_rd = reg_rd && reg_addr == 40'hFFFFF00168;
    wire perr = tag_read && (tag_parity_err || tag_ctl_parity_err);
    a_cfg_kept: assert property (timeout_reset |=> $stable(cfg))
        else $error("config changed under timeout reset");
    a_size_decode: assert property ($past(rst_n) && $stable(cache_size_field) |->
        cache_present == (cache_size_field != 3'h0)) else $error("size decode wrong");
    a_gap_start: assert property (private_read_done |-> ##2 write_hold)
        else $error("write hold late");
    a_gap_min: assert property ($rose(write_hold) |-> write_hold [*4])
        else $error("write hold too short");
    a_err_locks: assert property (perr |=> capture_locked)
        else $error("parity error did not lock");
    a_lock_stays: assert property (capture_locked && !st_rd && !force_hit_mode |=>
        capture_locked) else $error("lock dropped");
    a_status_unlock: assert property (st_rd && !perr |=> !capture_locked)
        else $error("status read did not unlock");
    a_force_map: assert property ($past(rst_n) |-> force_hit ==
        $past(force_hit_mode && cache_size_field != 3'h0 && cached_ref))
        else $error("force hit wrong");
    a_read_answer: assert property ($past(rst_n) |-> rdata_valid == $past(reg_rd))
        else $error("read answer timing wrong");
    a_cfg_hidden: assert property (reg_rd && reg_addr == 40'hFFFFF001C8 |=>
        reg_rdata == 64'h0) else $error("config read not zero");
endmodule

bind board_cache_timing_tag_capture cache_tag_checker u_chk (.*);

// file: verif/cache_array_model.sv
// Purpose: tag side of the board cache array, answers tag lookups
// Assumes: lookup is a one-cycle request held from a falling edge
// Notes: slow answers one cycle late; idle lines show the inverse value
module cache_array_model (
    input wire core_clk,
    input wire lookup,
    input wire [18:0] tag,
    input wire bad_tag,
    input wire slow,
    output logic tag_read = 1'b0,
    output logic [18:0] tag_bits = 19'h0,
    output logic tag_parity = 1'b0,
    output logic tag_parity_err = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic pend = 1'b0;
    wire go = (lookup && !slow) || pend;
    always @(posedge core_clk) begin
        pend <= lookup && slow;
        tag_read <= go;
        tag_bits <= go ? tag : ~tag_bits;
        tag_parity <= go ? ^tag ^ bad_tag : ~tag_parity;
        tag_parity_err <= go && bad_tag;
    end
endmodule

// file: verif/board_cache_timing_tag_capture_test.sv
// Purpose: self-checking bench for the board cache timing and tag capture
// Assumes: inputs move on the falling edge
// Notes: reset defaults first, then config rows; lock and pulse cases by hand
module board_cache_timing_tag_capture_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 0, rst_n = 0, timeout_reset = 0, reg_wr = 0, reg_rd = 0;
    logic [39:0] reg_addr = 40'h0;
    logic [63:0] reg_wdata = 64'h0, reg_rdata, d;
    logic force_hit_mode = 0, cached_ref = 0, system_cmd = 0, private_read_done = 0;
    logic private_write_start = 0, fill_write_start = 0, lookup = 0, bad_tag = 0, slow = 0;
    logic tag_read, tag_parity, tag_parity_err, rdata_valid, cache_present, force_hit;
    logic write_pulse, write_busy, write_hold, capture_locked, capture_suspect;
    logic [18:0] tag_bits, tag = 19'h0;
    logic [5:0] ctl = 6'h1F;
    logic [2:0] cache_size_field;
    logic [3:0] read_access_cycles, write_cycles;
    logic [15:0] v;
    wire tag_hit = ctl[0], tag_status_parity = ctl[1], tag_dirty_bit = ctl[2];
    wire tag_shared_bit = ctl[3], tag_valid_bit = ctl[4], tag_ctl_parity_err = ctl[5];
    wire [10:0] cfgo = {cache_size_field, read_access_cycles, write_cycles};
    int n_errors = 0, checks = 0, cyc = 0, n;
    // rows: config value, then expected size, read and write cycles
    logic [43:0] rows [8] = '{44'hE001_1440_044, 44'hE001_1561_165, 44'hE001_1A82_28A,
        44'hE001_1773_377, 44'hE001_1A94_49A, 44'hE001_1A75_57A, 44'hE001_1666_666,
        44'hE001_1457_754};
    board_cache_timing_tag_capture u_dut (.*);
    cache_array_model u_sram (.*);
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            final_report;
        end
    end
    task final_report;
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [63:0] cap(input logic [18:0] t, input logic p);
        cap = ({45'h0, t} << 20) | ({63'h0, p} << 17) | 64'h1F000;
    endfunction
    task rd(input logic [39:0] a);
        reg_rd = 1;
        reg_addr = a;
        @(negedge core_clk);
        chk(rdata_valid, 1);
        d = reg_rdata;
        reg_rd = 0;
    endtask
    // upper bits always set, the design must ignore them
    task cfg(input logic [31:0] c);
        reg_wr = 1;
        reg_addr = 40'hFFFFF001C8;
        reg_wdata = {32'hFFFF_FFFF, c};
        @(negedge core_clk) reg_wr = 0;
    endtask
    task look(input logic [18:0] t, input logic b);
        tag = t;
        bad_tag = b;
        lookup = 1;
        @(negedge core_clk) lookup = 0;
        repeat (3) @(negedge core_clk);
    endtask
    task gap_chk(input int e);
        private_read_done = 1;
        @(negedge core_clk) private_read_done = 0;
        n = 0;
        repeat (14) @(negedge core_clk) n += write_hold;
        chk(n, e);
    endtask
    task pulse(input logic f);
        private_write_start = !f;
        fill_write_start = f;
        for (int k = 0; k < 16; k++) begin
            @(negedge core_clk);
            private_write_start = 0;
            fill_write_start = 0;
            v[k] = write_pulse;
            if (k == 2) chk(write_busy, 1);
        end
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        rst_n = 1;
        @(negedge core_clk);
        chk(cfgo, 11'h144);
        gap_chk(10);
        foreach (rows[i]) begin
            cfg(rows[i][43:12]);
            repeat (2) @(negedge core_clk);
            chk(cfgo, rows[i][10:0]);
            chk(cache_present, rows[i][10:8] != 3'h0);
        end
        rd(40'hFFFFF001C8);
        chk(d, 0);
        rd(40'hFFFFF00100);
        chk(d, 0);
        timeout_reset = 1;
        cfg(32'h0);
        repeat (2) @(negedge core_clk);
        chk(cfgo, 11'h754);
        timeout_reset = 0;
        cfg(32'h1053_1441);
        gap_chk(4);
        pulse(0);
        chk(v, 16'h105 << 1);
        chk(write_busy, 0);
        pulse(1);
        chk(v, 16'h105 << 5);
        look(19'h5A5A5, 0);
        rd(40'hFFFFF00108);
        chk(d, cap(19'h5A5A5, ^19'h5A5A5));
        cfg(32'h1053_1443);
        look(19'h7FFFF, 0);
        rd(40'hFFFFF00108);
        chk(d, cap(19'h7FFFC, 1));
        ctl = 6'h3F;
        look(19'h12345, 0);
        ctl = 6'h1F;
        chk(capture_locked, 1);
        slow = 1;
        look(19'h00F0F, 0);
        rd(40'hFFFFF00108);
        chk(d, cap(19'h12344, ^19'h12345));
        rst_n = 0;
        repeat (2) @(negedge core_clk);
        rst_n = 1;
        @(negedge core_clk);
        chk(capture_locked, 1);
        chk(cfgo, 11'h144);
        rd(40'hFFFFF00168);
        chk(capture_locked, 0);
        look(19'h00F0F, 0);
        slow = 0;
        rd(40'hFFFFF00108);
        chk(d, cap(19'h00F0F, ^19'h00F0F));
        system_cmd = 1;
        look(19'h00001, 1);
        chk(capture_suspect, 1);
        chk(capture_locked, 1);
        system_cmd = 0;
        cached_ref = 1;
        force_hit_mode = 1;
        repeat (3) @(negedge core_clk);
        chk(capture_locked, 0);
        chk(force_hit, 1);
        cfg(32'h1053_1440);
        repeat (2) @(negedge core_clk);
        chk(force_hit, 0);
        final_report;
    end
endmodule
